// ### shared/tlc_pkg.sv
package tlc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register indices; the byte address of a register is four times its index.
   localparam int TLC_LINKS = 2;
   localparam logic [8:0] TLC_IDX_JITTER = 9'h021;
   localparam logic [8:0] TLC_IDX_CFG0 = 9'h022;
   localparam logic [8:0] TLC_IDX_CFG1 = 9'h023;
   localparam logic [8:0] TLC_IDX_SCALE = 9'h024;
   localparam logic [8:0] TLC_IDX_ACCESS = 9'h025;
   localparam logic [8:0] TLC_IDX_WDATA = 9'h026;
   localparam logic [8:0] TLC_LINK_STRIDE = 9'h100;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int TLC_JIT_BW_BIT = 0;
   localparam int TLC_JIT_DP_LSB = 1;
   localparam int TLC_CFG0_MD_BIT = 0;
   localparam int TLC_CFG0_OFF_BIT = 4;
   localparam int TLC_CFG1_PULS_LSB = 0;
   localparam int TLC_CFG1_HZ_BIT = 4;
   localparam int TLC_CFG1_DFM_BIT = 5;
   localparam int TLC_SCAL_LSB = 0;
   localparam int TLC_ACC_SAMP_LSB = 0;
   localparam int TLC_ACC_UI_LSB = 4;
   localparam int TLC_ACC_RW_BIT = 6;
   localparam int TLC_ACC_DONE_BIT = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // Values after reset.
   localparam logic [1:0] TLC_DP_RST = 2'h0;
   localparam logic TLC_BW_RST = 1'b0;
   localparam logic TLC_OFF_RST = 1'b0;
   localparam logic TLC_MD_RST = 1'b0;
   localparam logic TLC_DFM_RST = 1'b0;
   localparam logic TLC_HZ_RST = 1'b1;
   localparam logic [3:0] TLC_PULS_RST = 4'h0;
   localparam logic [5:0] TLC_SCAL_RST = 6'h21;
   localparam logic [6:0] TLC_WDAT_RST = 7'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Encodings.
   localparam logic [3:0] TLC_PULS_75 = 4'h0;
   localparam logic [3:0] TLC_PULS_120 = 4'h1;
   localparam logic [1:0] TLC_PULS_ARB_TOP = 2'h3;
   localparam logic [5:0] TLC_SCAL_NOMINAL = 6'h21;
   localparam logic [7:0] TLC_DEPTH_128 = 8'h80;
   localparam logic [7:0] TLC_DEPTH_64 = 8'h40;
   localparam logic [7:0] TLC_DEPTH_32 = 8'h20;
   localparam int TLC_UI_COUNT = 4;
   localparam int TLC_SAMPLE_COUNT = 16;
   localparam int TLC_TPL_WIDTH = 7;

   // Template access sequencer states.
   typedef enum logic [1:0] {
      TLC_ACC_IDLE,
      TLC_ACC_WRITE,
      TLC_ACC_READ,
      TLC_ACC_LOAD
   } tlc_acc_state_e;

endpackage

// ### verilog/tlc_template_ram.sv
`timescale 1ns/1ps

// Pulse template store with one write port and two synchronous read ports.
module tlc_template_ram
   import tlc_pkg::*;
#(
   parameter int DATA_W = TLC_TPL_WIDTH,
   parameter int DEPTH = TLC_UI_COUNT * TLC_SAMPLE_COUNT,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [AW-1:0] a_addr,
   output logic [DATA_W-1:0] a_data,
   input wire logic [AW-1:0] b_addr,
   output logic [DATA_W-1:0] b_data
);

   // The array needs a whole power of two so every address names a word.
   initial begin
      if (DEPTH != (1 << AW) || DATA_W < 1) begin
         $error("tlc_template_ram: DEPTH must be a power of two");
      end
   end

   // Template samples; contents are undefined until software loads them.
   logic [DATA_W-1:0] mem [DEPTH];

   ////////////////////////////////////////////////////////////////////////////////
   // Write port; the array carries no reset so it can map onto a RAM macro.
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Software read port, registered so the data appears one cycle later.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         a_data <= '0;
      end else begin
         a_data <= mem[a_addr];
      end
   end

   // Waveform generator read port, also one cycle of latency.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         b_data <= '0;
      end else begin
         b_data <= mem[b_addr];
      end
   end

endmodule

// ### verilog/tlc_tx_line_config.sv
`timescale 1ns/1ps

// Overview of operation
// - Depth code 00/01/1x gives 128/64/32 bits.
// - Bandwidth bit: 0 is 6.77 Hz, 1 is 0.87 Hz.
// - Power-down powers off path, driver goes high-Z.
// - Line code bit: 0 HDB3, 1 AMI.
// - Driver failure monitor runs only when enabled; resets off.
// - Tristate bit floats driver only; resets to one.
// - Shape code: 0000 75 ohm, 0001 120, 11xx arbitrary.
// - Amplitude scale acts only on arbitrary waveform.
// - Scale resets to 100001; step about three percent.
// - Template access works only with arbitrary shape.
// - Access enable bit permits or blocks template access.
// - Direction bit: 0 writes, 1 reads.
// - Unit interval field picks interval 0 to 3.
// - Sample field picks sample 0 to 15.
// - Second link copies sit 0x100 higher.
// - Separate seven-bit field supplies template write value.
module tlc_tx_line_config
   import tlc_pkg::*;
#(
   parameter int LINKS = TLC_LINKS,
   parameter int ADDR_W = 12
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [7:0] bus_rdata,
   output logic [LINKS-1:0][1:0] tx_jitter_depth_sel,
   output logic [LINKS-1:0][7:0] tx_jitter_depth_bits,
   output logic [LINKS-1:0] tx_jitter_bandwidth_sel,
   output logic [LINKS-1:0] tx_path_power_down,
   output logic [LINKS-1:0] line_driver_tristate,
   output logic [LINKS-1:0] tx_line_code_sel,
   output logic [LINKS-1:0] driver_fail_monitor_en,
   output logic [LINKS-1:0][3:0] pulse_shape_sel,
   output logic [LINKS-1:0] arbitrary_wave_sel,
   output logic [LINKS-1:0][5:0] amplitude_scale,
   output logic [LINKS-1:0][6:0] amplitude_offset_steps,
   input wire logic [LINKS-1:0][1:0] tpl_rd_ui,
   input wire logic [LINKS-1:0][3:0] tpl_rd_sample,
   output logic [LINKS-1:0][6:0] tpl_rd_data
);

   // The top register index is (LINKS-1)*0x100+0x26, four bytes per word.
   initial begin
      if (LINKS < 1 || LINKS > 2 || ADDR_W < 11) begin
         $error("tlc_tx_line_config: LINKS must be 1 or 2 and ADDR_W at least 11");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address decoding shared by the write and read paths.

   // True when the byte address is aligned and names register idx of a link.
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input int link,
                                    input logic [8:0] idx);
      logic [ADDR_W-3:0] want;
      want = (ADDR_W-2)'(int'(idx) + link * int'(TLC_LINK_STRIDE));
      reg_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == want);
   endfunction

   // Elastic store depth in bits for a depth code.
   function automatic logic [7:0] depth_bits(input logic [1:0] code);
      case (code)
         2'h0: depth_bits = TLC_DEPTH_128;
         2'h1: depth_bits = TLC_DEPTH_64;
         default: depth_bits = TLC_DEPTH_32;
      endcase
   endfunction

   // Read word of each link; unmapped addresses leave every word at zero.
   logic [LINKS-1:0][7:0] link_word;

   ////////////////////////////////////////////////////////////////////////////////
   // One copy of the register set and template store per link.
   for (genvar g = 0; g < LINKS; g++) begin : g_link
      logic [1:0] depth_r; // Jitter store depth code.
      logic bw_r; // Jitter corner choice.
      logic off_r; // Transmit path power-down.
      logic md_r; // Line code choice.
      logic dfm_r; // Driver failure monitor enable.
      logic hz_r; // Driver high-impedance request.
      logic [3:0] puls_r; // Pulse shape code.
      logic [5:0] scal_r; // Amplitude scale.
      logic done_r; // Template access enable, cleared when the access ends.
      logic rw_r; // Template access direction.
      logic [1:0] ui_r; // Template unit interval address.
      logic [3:0] samp_r; // Template sample address.
      logic [6:0] wdat_r; // Template data, written or read back.
      tlc_acc_state_e acc_r; // Template access sequencer.
      tlc_acc_state_e acc_nxt;
      logic arb; // Arbitrary waveform selected.
      logic launch; // Software starts an access this cycle.
      logic [6:0] sw_rd_data; // Template word for software.
      logic [5:0] tpl_addr; // Software template address.

      assign arb = (puls_r[3:2] == TLC_PULS_ARB_TOP);
      assign tpl_addr = {ui_r, samp_r};
      // An access starts only when enabled and the arbitrary shape is chosen.
      assign launch = bus_write && reg_hit(bus_addr, g, TLC_IDX_ACCESS)
                      && bus_wdata[TLC_ACC_DONE_BIT] && arb;

      // Jitter attenuator fields.
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            depth_r <= TLC_DP_RST;
            bw_r <= TLC_BW_RST;
         end else if (bus_write && reg_hit(bus_addr, g, TLC_IDX_JITTER)) begin
            depth_r <= bus_wdata[TLC_JIT_DP_LSB +: 2];
            bw_r <= bus_wdata[TLC_JIT_BW_BIT];
         end
      end

      // Power-down and line code.
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            off_r <= TLC_OFF_RST;
            md_r <= TLC_MD_RST;
         end else if (bus_write && reg_hit(bus_addr, g, TLC_IDX_CFG0)) begin
            off_r <= bus_wdata[TLC_CFG0_OFF_BIT];
            md_r <= bus_wdata[TLC_CFG0_MD_BIT];
         end
      end

      // Monitor enable, driver float and pulse shape.
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            dfm_r <= TLC_DFM_RST;
            hz_r <= TLC_HZ_RST;
            puls_r <= TLC_PULS_RST;
         end else if (bus_write && reg_hit(bus_addr, g, TLC_IDX_CFG1)) begin
            dfm_r <= bus_wdata[TLC_CFG1_DFM_BIT];
            hz_r <= bus_wdata[TLC_CFG1_HZ_BIT];
            puls_r <= bus_wdata[TLC_CFG1_PULS_LSB +: 4];
         end
      end

      // Amplitude scale; the stored value is kept whatever shape is chosen.
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            scal_r <= TLC_SCAL_RST;
         end else if (bus_write && reg_hit(bus_addr, g, TLC_IDX_SCALE)) begin
            scal_r <= bus_wdata[TLC_SCAL_LSB +: 6];
         end
      end

      // Access sequencer: a write takes one cycle, a read two because the
      // store reads synchronously. Leaving the arbitrary shape aborts it.
      always_comb begin
         acc_nxt = acc_r;
         if (launch) begin
            acc_nxt = bus_wdata[TLC_ACC_RW_BIT] ? TLC_ACC_READ : TLC_ACC_WRITE;
         end else if (!arb) begin
            acc_nxt = TLC_ACC_IDLE;
         end else begin
            case (acc_r)
               TLC_ACC_IDLE: acc_nxt = TLC_ACC_IDLE;
               TLC_ACC_WRITE: acc_nxt = TLC_ACC_IDLE;
               TLC_ACC_READ: acc_nxt = TLC_ACC_LOAD;
               TLC_ACC_LOAD: acc_nxt = TLC_ACC_IDLE;
               default: acc_nxt = TLC_ACC_IDLE;
            endcase
         end
      end

      // Sequencer state register.
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            acc_r <= TLC_ACC_IDLE;
         end else begin
            acc_r <= acc_nxt;
         end
      end

      // Access control fields. A software write in the cycle the access
      // ends wins over the hardware clear of the enable bit.
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            done_r <= 1'b0;
            rw_r <= 1'b0;
            ui_r <= 2'h0;
            samp_r <= 4'h0;
         end else if (bus_write && reg_hit(bus_addr, g, TLC_IDX_ACCESS)) begin
            // Without the arbitrary shape the enable is not kept.
            done_r <= bus_wdata[TLC_ACC_DONE_BIT] && arb;
            rw_r <= bus_wdata[TLC_ACC_RW_BIT];
            ui_r <= bus_wdata[TLC_ACC_UI_LSB +: 2];
            samp_r <= bus_wdata[TLC_ACC_SAMP_LSB +: 4];
         end else if (acc_nxt == TLC_ACC_IDLE) begin
            done_r <= 1'b0;
         end
      end

      // Template data. A read result overrides a software write landing in
      // the same cycle, so the returned word is never lost.
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            wdat_r <= TLC_WDAT_RST;
         end else if (acc_r == TLC_ACC_LOAD && arb) begin
            wdat_r <= sw_rd_data;
         end else if (bus_write && reg_hit(bus_addr, g, TLC_IDX_WDATA)) begin
            wdat_r <= bus_wdata[6:0];
         end
      end

      // Template store shared by software and the waveform generator.
      tlc_template_ram #(
         .DATA_W(TLC_TPL_WIDTH),
         .DEPTH(TLC_UI_COUNT * TLC_SAMPLE_COUNT),
         .AW(6)
      ) u_ram (
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .wr_en(acc_r == TLC_ACC_WRITE && arb),
         .wr_addr(tpl_addr),
         .wr_data(wdat_r),
         .a_addr(tpl_addr),
         .a_data(sw_rd_data),
         .b_addr({tpl_rd_ui[g], tpl_rd_sample[g]}),
         .b_data(tpl_rd_data[g])
      );

      // Read word of this link; reserved bits read as zero.
      always_comb begin
         link_word[g] = 8'h00;
         if (reg_hit(bus_addr, g, TLC_IDX_JITTER)) begin
            link_word[g] = {5'h00, depth_r, bw_r};
         end else if (reg_hit(bus_addr, g, TLC_IDX_CFG0)) begin
            link_word[g] = {3'h0, off_r, 3'h0, md_r};
         end else if (reg_hit(bus_addr, g, TLC_IDX_CFG1)) begin
            link_word[g] = {2'h0, dfm_r, hz_r, puls_r};
         end else if (reg_hit(bus_addr, g, TLC_IDX_SCALE)) begin
            link_word[g] = {2'h0, scal_r};
         end else if (reg_hit(bus_addr, g, TLC_IDX_ACCESS)) begin
            link_word[g] = {done_r, rw_r, ui_r, samp_r};
         end else if (reg_hit(bus_addr, g, TLC_IDX_WDATA)) begin
            link_word[g] = {1'b0, wdat_r};
         end
      end

      // Controls straight from the registers.
      assign tx_jitter_depth_sel[g] = depth_r;
      assign tx_jitter_bandwidth_sel[g] = bw_r;
      assign tx_path_power_down[g] = off_r;
      assign tx_line_code_sel[g] = md_r;
      assign pulse_shape_sel[g] = puls_r;

      // Derived controls, registered so that they are glitch free at the
      // driver; they lag a register write by one cycle.
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            tx_jitter_depth_bits[g] <= TLC_DEPTH_128;
            line_driver_tristate[g] <= 1'b1;
            driver_fail_monitor_en[g] <= 1'b0;
            arbitrary_wave_sel[g] <= 1'b0;
            amplitude_scale[g] <= TLC_SCAL_NOMINAL;
            amplitude_offset_steps[g] <= 7'h00;
         end else begin
            tx_jitter_depth_bits[g] <= depth_bits(depth_r);
            // Power-down floats the driver too; the float bit alone
            // leaves the rest of the path running.
            line_driver_tristate[g] <= off_r | hz_r;
            // A powered-down driver cannot fail, so the monitor rests too.
            driver_fail_monitor_en[g] <= dfm_r && !off_r;
            arbitrary_wave_sel[g] <= arb;
            // Fixed shapes always use nominal amplitude.
            amplitude_scale[g] <= arb ? scal_r : TLC_SCAL_NOMINAL;
            // Signed steps from nominal, about three percent each.
            amplitude_offset_steps[g] <= arb ? 7'({1'b0, scal_r} - {1'b0, TLC_SCAL_NOMINAL})
                                             : 7'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, valid in the cycle after the read strobe only.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bus_rdata <= 8'h00;
      end else if (bus_read) begin
         bus_rdata <= bus_rdata_mux(link_word);
      end else begin
         bus_rdata <= 8'h00;
      end
   end

   // Combines the per-link read words; at most one is non-zero.
   function automatic logic [7:0] bus_rdata_mux(input logic [LINKS-1:0][7:0] w);
      logic [7:0] acc;
      acc = 8'h00;
      for (int i = 0; i < LINKS; i++) begin
         acc = acc | w[i];
      end
      bus_rdata_mux = acc;
   endfunction

endmodule

// ### testbench/tlc_tx_line_config_checker.sv
`timescale 1ns/1ps

// Watches the register bus and the per-link line controls of the configuration block.
module tlc_tx_line_config_checker
   import tlc_pkg::*;
#(
   parameter int LINKS = TLC_LINKS,
   parameter int ADDR_W = 12
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   input wire logic [7:0] bus_rdata,
   input wire logic [LINKS-1:0][1:0] tx_jitter_depth_sel,
   input wire logic [LINKS-1:0][7:0] tx_jitter_depth_bits,
   input wire logic [LINKS-1:0] tx_path_power_down,
   input wire logic [LINKS-1:0] line_driver_tristate,
   input wire logic [LINKS-1:0] tx_line_code_sel,
   input wire logic [LINKS-1:0] driver_fail_monitor_en,
   input wire logic [LINKS-1:0][3:0] pulse_shape_sel,
   input wire logic [LINKS-1:0] arbitrary_wave_sel,
   input wire logic [LINKS-1:0][5:0] amplitude_scale,
   input wire logic [LINKS-1:0][6:0] amplitude_offset_steps
);
   // Byte addresses of the power and line code register on each link.
   localparam logic [ADDR_W-1:0] CFG0_L1 = ADDR_W'({TLC_IDX_CFG0, 2'b00});
   localparam logic [ADDR_W-1:0] CFG0_L2 = ADDR_W'({TLC_IDX_CFG0 + TLC_LINK_STRIDE, 2'b00});

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // A write to the first link's register, then a read of it after one idle cycle.
   sequence cfg0_wr_s;
      bus_write && bus_addr == CFG0_L1;
   endsequence
   sequence cfg0_rd_s;
      bus_read && bus_addr == CFG0_L1;
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after a read strobe.
   rdata_idle_a: assert property (!$past(bus_read) |-> bus_rdata == 8'h00)
      else $error("read data not zero outside the read answer");
   cfg0_echo_a: assert property (
      cfg0_wr_s ##1 !bus_write ##1 cfg0_rd_s |=> bus_rdata == ($past(bus_wdata, 3) & 8'h11))
      else $error("power and line code register read back wrong");
   cfg0_apply_a: assert property (cfg0_wr_s |=>
      tx_path_power_down[0] == $past(bus_wdata[TLC_CFG0_OFF_BIT]) &&
      tx_line_code_sel[0] == $past(bus_wdata[TLC_CFG0_MD_BIT]))
      else $error("power or line code output not taken from write");
   link_copy_a: assert property (bus_write && bus_addr == CFG0_L2 |=>
      tx_line_code_sel[1] == $past(bus_wdata[0]) && $stable(tx_line_code_sel[0]))
      else $error("second link write landed on the wrong link");

   ////////////////////////////////////////////////////////////////////////////////
   // Derived controls follow the stored fields one cycle later.
   depth_map_a: assert property (tx_jitter_depth_bits[0] ==
      ($past(tx_jitter_depth_sel[0]) == 2'h0 ? 8'h80 :
       $past(tx_jitter_depth_sel[0]) == 2'h1 ? 8'h40 : 8'h20))
      else $error("elastic store depth does not match its code");
   power_float_a: assert property (
      $past(tx_path_power_down[0]) |-> line_driver_tristate[0])
      else $error("driver not floated while powered down");
   monitor_gate_a: assert property (
      driver_fail_monitor_en[0] |-> !$past(tx_path_power_down[0]))
      else $error("driver monitor running while powered down");
   arb_decode_a: assert property (
      arbitrary_wave_sel[0] == ($past(pulse_shape_sel[0][3:2]) == 2'h3))
      else $error("arbitrary waveform decode wrong");
   scale_ignore_a: assert property (!arbitrary_wave_sel[0] |->
      amplitude_scale[0] == TLC_SCAL_NOMINAL && amplitude_offset_steps[0] == 7'h00)
      else $error("amplitude scale applied to a fixed shape");
   scale_steps_a: assert property (arbitrary_wave_sel[0] |-> amplitude_offset_steps[0] ==
      7'({1'b0, amplitude_scale[0]} - {1'b0, TLC_SCAL_NOMINAL}))
      else $error("amplitude step count wrong");
endmodule

bind tlc_tx_line_config tlc_tx_line_config_checker #(.LINKS(LINKS), .ADDR_W(ADDR_W)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
   .tx_jitter_depth_sel(tx_jitter_depth_sel), .tx_jitter_depth_bits(tx_jitter_depth_bits),
   .tx_path_power_down(tx_path_power_down), .line_driver_tristate(line_driver_tristate),
   .tx_line_code_sel(tx_line_code_sel), .driver_fail_monitor_en(driver_fail_monitor_en),
   .pulse_shape_sel(pulse_shape_sel), .arbitrary_wave_sel(arbitrary_wave_sel),
   .amplitude_scale(amplitude_scale), .amplitude_offset_steps(amplitude_offset_steps));

// ### testbench/testbench.sv
`timescale 1ns/1ps

module testbench;
   import tlc_pkg::*;
   // Bus master and waveform generator port, all driven by this bench.
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] bus_addr = 12'h000;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_write = 1'b0;
   logic bus_read = 1'b0;
   logic [7:0] bus_rdata;
   logic [1:0][1:0] dsel, g_ui = '0;
   logic [1:0][7:0] dbits;
   logic [1:0] bw, pdown, tri_o, lcode, mon, arb;
   logic [1:0][3:0] shape, g_s = '0;
   logic [1:0][5:0] scale;
   logic [1:0][6:0] steps, g_d;
   logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h10, 8'h21, 8'h00, 8'h00};
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;

   tlc_tx_line_config #(.LINKS(2), .ADDR_W(12)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
      .tx_jitter_depth_sel(dsel), .tx_jitter_depth_bits(dbits), .tx_jitter_bandwidth_sel(bw),
      .tx_path_power_down(pdown), .line_driver_tristate(tri_o), .tx_line_code_sel(lcode),
      .driver_fail_monitor_en(mon), .pulse_shape_sel(shape), .arbitrary_wave_sel(arb),
      .amplitude_scale(scale), .amplitude_offset_steps(steps), .tpl_rd_ui(g_ui),
      .tpl_rd_sample(g_s), .tpl_rd_data(g_d));

   // Free-running 250 MHz clock.
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops the run.
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Compares one value; four-state equality so an unknown never matches.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Byte address of a register index on a link.
   function automatic logic [11:0] adr(input int l, input logic [8:0] idx);
      return {1'b0, idx + (l != 0 ? TLC_LINK_STRIDE : 9'h000), 2'b00};
   endfunction

   // Expected elastic store depth for a depth code.
   function automatic logic [7:0] exp_depth(input logic [1:0] c);
      return (c == 2'h0) ? 8'h80 : (c == 2'h1) ? 8'h40 : 8'h20;
   endfunction

   // One-cycle write; the strobe drops at the next edge, leaving a gap cycle.
   task automatic wr(input int l, input logic [8:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      bus_write <= 1'b1;
      bus_addr <= adr(l, idx);
      bus_wdata <= d;
      @(posedge clk_sys);
      bus_write <= 1'b0;
   endtask

   // One-cycle read; data are taken in the single cycle that they stand.
   task automatic rd(input int l, input logic [8:0] idx, input logic [7:0] exp);
      @(posedge clk_sys);
      bus_read <= 1'b1;
      bus_addr <= adr(l, idx);
      @(posedge clk_sys);
      bus_read <= 1'b0;
      #1 chk(bus_rdata, exp, "register read");
   endtask

   // Reads a template word through the generator port, one cycle after the address.
   task automatic gen(input int l, input logic [5:0] a, input logic [6:0] e);
      @(posedge clk_sys);
      g_ui <= {a[5:4], a[5:4]};
      g_s <= {a[3:0], a[3:0]};
      @(posedge clk_sys);
      #1 chk(g_d[l], e, "template word");
   endtask

   // Lets derived outputs, which trail the registers by a cycle, settle.
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   // A hang is cut short well beyond the expected run of about 820 cycles.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int l;
      logic [7:0] d, e, c;
      logic [5:0] s, a;
      logic [6:0] v;
      logic [7:0] cfg0_m [2];
      void'($urandom(32'h632fcc74));
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Reset contents of every register on both links.
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 6; i++) begin
            rd(k, TLC_IDX_JITTER + 9'(i), rstv[i]);
         end
         chk(tri_o[k], 1'b1, "driver float at reset");
         cfg0_m[k] = 8'h00;
      end
      // Random configuration on random links; the depth code walks all four values.
      for (int i = 0; i < 24; i++) begin
         l = $urandom % 2;
         d = {5'($urandom), 2'(i), 1'($urandom)};
         e = 8'($urandom);
         c = 8'($urandom);
         s = 6'($urandom);
         wr(l, TLC_IDX_JITTER, d);
         wr(l, TLC_IDX_CFG0, e);
         rd(l, TLC_IDX_CFG0, e & 8'h11);
         cfg0_m[l] = e & 8'h11;
         wr(l, TLC_IDX_SCALE, {2'(e), s});
         wr(l, TLC_IDX_CFG1, c);
         rd(l, TLC_IDX_JITTER, d & 8'h07);
         rd(l, TLC_IDX_SCALE, {2'h0, s});
         rd(l, TLC_IDX_CFG1, c & 8'h3F);
         settle();
         chk(dsel[l], d[2:1], "depth code");
         chk(dbits[l], exp_depth(d[2:1]), "depth");
         chk(bw[l], d[0], "bandwidth");
         chk(pdown[l], e[4], "power down");
         chk(tri_o[l], c[4] | e[4], "driver float");
         chk(mon[l], c[5] & ~e[4], "driver monitor");
         chk(shape[l], c[3:0], "pulse shape");
         chk(arb[l], c[3:2] == 2'h3, "arbitrary select");
         chk(scale[l], (c[3:2] == 2'h3) ? s : 6'h21, "scale");
         chk(steps[l], (c[3:2] == 2'h3) ? 7'({1'b0, s} - 7'h21) : 7'h00, "steps");
         chk(lcode[0], cfg0_m[0][0], "line code link one");
         chk(lcode[1], cfg0_m[1][0], "line code link two");
         chk(pdown[1 - l], cfg0_m[1 - l][4], "power other link");
      end
      // Template writes and read-backs at corner and random addresses on both links.
      for (int k = 0; k < 2; k++) begin
         wr(k, TLC_IDX_CFG1, 8'h0C | 8'($urandom % 4));
         for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
            v = 7'($urandom);
            wr(k, TLC_IDX_WDATA, {1'b0, v});
            wr(k, TLC_IDX_ACCESS, {2'b10, a});
            repeat (2) @(posedge clk_sys);
            rd(k, TLC_IDX_ACCESS, {2'b00, a});
            gen(k, a, v);
            wr(k, TLC_IDX_WDATA, 8'h00);
            wr(k, TLC_IDX_ACCESS, {2'b11, a});
            repeat (3) @(posedge clk_sys);
            rd(k, TLC_IDX_WDATA, {1'b0, v});
         end
         // Access with the enable clear, then with a fixed shape, must not write.
         wr(k, TLC_IDX_WDATA, {1'b0, ~v});
         wr(k, TLC_IDX_ACCESS, {2'b00, a});
         gen(k, a, v);
         wr(k, TLC_IDX_CFG1, 8'h01);
         wr(k, TLC_IDX_ACCESS, {2'b10, a});
         rd(k, TLC_IDX_ACCESS, {2'b00, a});
         repeat (2) @(posedge clk_sys);
         gen(k, a, v);
      end
      // Unmapped place: writes are dropped and reads give zero.
      wr(0, 9'h027, 8'hFF);
      rd(0, 9'h027, 8'h00);
      test_done();
   end
endmodule
